// file: bench/tcep_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// external pins around channel 1 and 2
// ----------------------------------------
module tcep_pin_model (
    input  wire logic sys_clk,
    input  wire logic in_lvl,
    input  wire logic main_lvl,
    input  wire logic main_oe,
    output logic      filt1,
    output logic      filt2,
    output logic      pin_lvl
);
    // source pins resync to the kernel clock, so they only move on the clock edge
    always_ff @(posedge sys_clk) begin
        filt1 <= in_lvl;
        filt2 <= in_lvl;
    end

    // pad has a pull-down: a released pin reads low
    assign pin_lvl = main_oe ? main_lvl : 1'b0;

endmodule : tcep_pin_model

`default_nettype wire

// file: bench/test_timer_channel_enable_polarity.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end

module test_timer_channel_enable_polarity;
    logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  lock_level, dir1, dir2, code;
    logic        cpe, comm, mo_en, idle_off, run_off, idl1, idln1, idl2, ref1, in_lvl;
    logic        f1, f2, o1, oe1, n1, noe1, o2, oe2, cap1, cap2;
    logic        r1, fl1, r2, fl2, ic1, ic2, pin1;
    int          err_total, total_checks;

    tcep_top #(.ADDR_W(8)) u_tcep_top (
        .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lock_level(lock_level),
        .ch1_direction_select(dir1), .ch2_direction_select(dir2),
        .control_preload_enable(cpe), .commutation_event(comm),
        .main_output_enable(mo_en), .idle_offstate_select(idle_off),
        .run_offstate_select(run_off), .ch1_idle_level(idl1),
        .ch1_comp_idle_level(idln1), .ch2_idle_level(idl2),
        .ch1_reference_signal(ref1), .ch2_reference_signal(ref1),
        .ch1_filtered_input(f1), .ch2_filtered_input(f2),
        .ch1_main_output(o1), .ch1_main_oe(oe1), .ch1_comp_output(n1),
        .ch1_comp_oe(noe1), .ch2_main_output(o2), .ch2_main_oe(oe2),
        .ch1_capture_en(cap1), .ch2_capture_en(cap2), .ch1_edge_rise(r1),
        .ch1_edge_fall(fl1), .ch2_edge_rise(r2), .ch2_edge_fall(fl2),
        .ch1_input_cond(ic1), .ch2_input_cond(ic2)
    );

    tcep_pin_model u_tcep_pin_model (
        .sys_clk(sys_clk), .in_lvl(in_lvl), .main_lvl(o1), .main_oe(oe1),
        .filt1(f1), .filt2(f2), .pin_lvl(pin1)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // write, then let the word reach the pins
    task automatic wr(input logic [7:0] d);
        apb(1'b1, 8'h20, d);
        repeat (4) @(posedge sys_clk);
    endtask : wr

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, 8'h20, 8'h00);
        `CHK("reset word", 32'h0000_0000, rd)
        apb(1'b1, 8'h20, 8'hFF);
        apb(1'b0, 8'h20, 8'h00);
        `CHK("reserved bits", 32'h0000_00BF, rd)
        apb(1'b1, 8'h24, 8'h01);
        `CHK("unmapped err", 1'b1, err)
        wr(8'h00);
    endtask : t_regs

    task automatic t_out;
        logic p;
        mo_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            p = i[0];
            ref1 <= i[1];
            wr({2'b00, p, 1'b1, 2'b00, p, 1'b1});
            `CHK("main lvl", i[1] ^ p, o1)
            `CHK("main oe", 1'b1, oe1)
            `CHK("comp oe off", 1'b0, noe1)
            `CHK("ch2 lvl", i[1] ^ p, o2)
            `CHK("ch2 oe", 1'b1, oe2)
            `CHK("pin lvl", i[1] ^ p, pin1)
            wr({4'h0, p, 3'b100});
            `CHK("comp lvl", i[1] ^ p, n1)
            `CHK("comp oe", 1'b1, noe1)
            `CHK("main off", 1'b0, oe1)
        end
        wr(8'h00);
    endtask : t_out

    task automatic t_in;
        dir1 <= 2'b01;
        dir2 <= 2'b11;
        // code 10 is reserved and never written; no encoder mode here
        for (int k = 0; k < 3; k++) begin
            code = (k == 0) ? 2'b00 : (k == 1) ? 2'b01 : 2'b11;
            wr({code[1], 1'b0, code[0], 1'b1, code[1], 1'b0, code[0], 1'b1});
            for (int l = 0; l < 2; l++) begin
                in_lvl <= l[0];
                repeat (4) @(posedge sys_clk);
                `CHK("rise", code != 2'b01, r1)
                `CHK("fall", code != 2'b00, fl1)
                `CHK("cond", l[0] ^ (code == 2'b01), ic1)
                `CHK("ch2 fall", code != 2'b00, fl2)
                `CHK("ch2 rise", code != 2'b01, r2)
                `CHK("ch2 cond", l[0] ^ (code == 2'b01), ic2)
                `CHK("capture", 1'b1, cap1 & cap2)
                `CHK("input oe", 1'b0, oe1)
            end
        end
        wr(8'h00);
        `CHK("capture off", 1'b0, cap1)
        dir1 <= 2'b00;
        dir2 <= 2'b00;
    endtask : t_in

    task automatic t_lock;
        wr(8'h01);
        lock_level <= 2'b10;
        wr(8'h0B);
        apb(1'b0, 8'h20, 8'h00);
        `CHK("locked out", 32'h0000_0001, rd)
        dir1 <= 2'b01;
        lock_level <= 2'b11;
        wr(8'h0B);
        apb(1'b0, 8'h20, 8'h00);
        `CHK("locked in", 32'h0000_0009, rd)
        lock_level <= 2'b00;
        dir1 <= 2'b00;
        wr(8'h00);
    endtask : t_lock

    task automatic t_preload;
        ref1 <= 1'b0;
        cpe <= 1'b1;
        wr(8'h03);
        `CHK("held oe", 1'b0, oe1)
        apb(1'b0, 8'h30, 8'h00);
        `CHK("held bits", 32'h0000_0000, rd)
        comm <= 1'b1;
        @(posedge sys_clk);
        comm <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK("loaded oe", 1'b1, oe1)
        `CHK("loaded pol", 1'b1, o1)
        cpe <= 1'b0;
        wr(8'h00);
        `CHK("direct oe", 1'b0, oe1)
    endtask : t_preload

    task automatic t_idle;
        run_off <= 1'b1;
        wr(8'h06);
        `CHK("off lvl", 1'b1, o1)
        `CHK("off oe", 1'b1, oe1)
        `CHK("run comp lvl", 1'b0, n1)
        run_off <= 1'b0;
        wr(8'h05);
        `CHK("both main", 1'b0, o1)
        `CHK("both comp", 1'b1, n1)
        `CHK("both comp oe", 1'b1, noe1)
        mo_en <= 1'b0;
        idle_off <= 1'b1;
        idl1 <= 1'b1;
        idln1 <= 1'b1;
        wr(8'h01);
        `CHK("idle lvl", 1'b1, o1)
        `CHK("idle oe", 1'b1, oe1)
        `CHK("idle comp lvl", 1'b1, n1)
        idle_off <= 1'b0;
        wr(8'h01);
        `CHK("idle off", 1'b0, oe1)
        idl1 <= 1'b0;
        idln1 <= 1'b0;
        wr(8'h00); // unused channel left with idle and polarity cleared
    endtask : t_idle

    initial begin
        {nrst, psel, penable, pwrite, cpe, comm, mo_en, idle_off, run_off} = 9'h000;
        {idl1, idln1, idl2, ref1, in_lvl} = 5'h00;
        {lock_level, dir1, dir2, code} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_total = 0;
        total_checks = 0;
        repeat (20) @(posedge sys_clk);
        nrst <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_lock();
        t_preload();
        t_idle();
        complete_run();
    end

endmodule : test_timer_channel_enable_polarity

`default_nettype wire

// file: hw/tcep_chan_out.sv
`timescale 1ns/1ps
`default_nettype none

module tcep_chan_out (
    input  wire tcep_pkg::tcep_chan_ctl_t ctl,
    input  wire tcep_pkg::tcep_brk_t      brk,
    input  wire logic                     idle_lvl,
    input  wire logic                     comp_idle_lvl,
    input  wire logic                     ref_sig,
    input  wire logic                     is_output,
    output var  tcep_pkg::tcep_pin_t      main_pin,
    output var  tcep_pkg::tcep_pin_t      comp_pin
);

    always_comb begin
        main_pin = '0;
        comp_pin = '0;
        if (!is_output) begin
            main_pin = '0;
            comp_pin = '0;
        end else if (brk.main_output_enable) begin
            // run state: main pin is reference xor polarity, comp pin uses inverted reference when both enabled, or its off state
            if (ctl.out_en) begin
                main_pin.lvl = ref_sig ^ ctl.pol;
                main_pin.oe  = 1'b1;
            end else if (brk.run_offstate_select) begin
                main_pin.lvl = ctl.pol;
                main_pin.oe  = ctl.comp_en;
            end
            if (ctl.comp_en) begin
                comp_pin.lvl = (ctl.out_en ? ~ref_sig : ref_sig) ^ ctl.comp_pol;
                comp_pin.oe  = 1'b1;
            end else if (brk.run_offstate_select) begin
                comp_pin.lvl = ctl.comp_pol;
                comp_pin.oe  = ctl.out_en;
            end
        end else if (brk.idle_offstate_select && (ctl.out_en || ctl.comp_en)) begin
            // idle state: pins held at their idle levels
            main_pin.lvl = idle_lvl;
            main_pin.oe  = 1'b1;
            comp_pin.lvl = comp_idle_lvl;
            comp_pin.oe  = 1'b1;
        end
    end

endmodule : tcep_chan_out

`default_nettype wire

// file: hw/tcep_top.sv
// How it works
// - ch1 enable gates capture and main output
// - ch1 output polarity: 0 high, 1 low
// - input code 00 rise, 01 fall, 11 both
// - gated/encoder input inverted only for code 01
// - ch1 complementary polarity: 0 high, 1 low
// - comp polarity locked at level 2+ if output
// - main polarity locked at lock level 2+
// - comp enable gates complementary output pin
// - pin levels from enables, off-states, idle levels
// - preload holds ch1 polarity until commutation
// - preload holds ch1 enable until commutation
// - ch2 bits behave like ch1 counterparts, but preload does not hold them
// - direction 00 is output, others input
// - run, main only: reference xor polarity driven
`timescale 1ns/1ps
`default_nettype none
`include "tcep_map.svh"

module tcep_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        lock_level,
    input  wire logic [1:0]        ch1_direction_select,
    input  wire logic [1:0]        ch2_direction_select,
    input  wire logic              control_preload_enable,
    input  wire logic              commutation_event,
    input  wire logic              main_output_enable,
    input  wire logic              idle_offstate_select,
    input  wire logic              run_offstate_select,
    input  wire logic              ch1_idle_level,
    input  wire logic              ch1_comp_idle_level,
    input  wire logic              ch2_idle_level,
    input  wire logic              ch1_reference_signal,
    input  wire logic              ch2_reference_signal,
    input  wire logic              ch1_filtered_input,
    input  wire logic              ch2_filtered_input,
    output logic                   ch1_main_output,
    output logic                   ch1_main_oe,
    output logic                   ch1_comp_output,
    output logic                   ch1_comp_oe,
    output logic                   ch2_main_output,
    output logic                   ch2_main_oe,
    output logic                   ch1_capture_en,
    output logic                   ch2_capture_en,
    output logic                   ch1_edge_rise,
    output logic                   ch1_edge_fall,
    output logic                   ch2_edge_rise,
    output logic                   ch2_edge_fall,
    output logic                   ch1_input_cond,
    output logic                   ch2_input_cond
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_out(input logic [1:0] dir);
        return dir == `TCEP_DIR_OUT;
    endfunction : is_out

    function automatic logic [7:0] pack_word(input tcep_pkg::tcep_chan_ctl_t c1,
                                             input tcep_pkg::tcep_chan_ctl_t c2);
        logic [7:0] w;
        w = '0;
        w[`TCEP_CH1_EN_BIT]   = c1.out_en;
        w[`TCEP_CH1_POL_BIT]  = c1.pol;
        w[`TCEP_CH1_NEN_BIT]  = c1.comp_en;
        w[`TCEP_CH1_NPOL_BIT] = c1.comp_pol;
        w[`TCEP_CH2_EN_BIT]   = c2.out_en;
        w[`TCEP_CH2_POL_BIT]  = c2.pol;
        w[`TCEP_CH2_NPOL_BIT] = c2.comp_pol;
        return w;
    endfunction : pack_word

    // rise/fall sensitivity from the {comp_pol, pol} input code
    function automatic logic [1:0] edge_sel(input tcep_pkg::tcep_chan_ctl_t c);
        return {c.comp_pol | ~c.pol, c.pol};
    endfunction : edge_sel

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic       setup_cyc;
    logic       wr_cyc;
    logic       hit_cep;
    logic       hit_stat;
    logic       prot1;
    logic       prot_n1;
    logic       prot_n2;
    logic [7:0] wr_word;
    logic [7:0] cep_q;

    assign setup_cyc = psel && !penable;
    assign wr_cyc    = psel && penable && pready && pwrite;
    assign hit_cep   = paddr == ADDR_W'(`TCEP_CEP_OFF);
    assign hit_stat  = paddr == ADDR_W'(`TCEP_STAT_OFF);
    assign prot1     = lock_level >= `TCEP_LOCK_PROT;
    assign prot_n1   = prot1 && is_out(ch1_direction_select);
    assign prot_n2   = prot1 && is_out(ch2_direction_select);

    // locked polarity bits keep their value, reserved bits drop
    always_comb begin
        wr_word = pwdata[7:0] & `TCEP_CEP_MASK;
        if (prot1) begin
            wr_word[`TCEP_CH1_POL_BIT] = cep_q[`TCEP_CH1_POL_BIT];
            wr_word[`TCEP_CH2_POL_BIT] = cep_q[`TCEP_CH2_POL_BIT];
        end
        if (prot_n1) begin
            wr_word[`TCEP_CH1_NPOL_BIT] = cep_q[`TCEP_CH1_NPOL_BIT];
        end
        if (prot_n2) begin
            wr_word[`TCEP_CH2_NPOL_BIT] = cep_q[`TCEP_CH2_NPOL_BIT];
        end
    end

    // ----------------------------------------------------------------
    // written (shadow) register
    // ----------------------------------------------------------------
    // word as written by software, locked bits already merged

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cep_q <= `TCEP_CEP_RST;
        end else if (wr_cyc && hit_cep) begin
            cep_q <= wr_word;
        end
    end

    tcep_pkg::tcep_chan_ctl_t ch1_shd;
    tcep_pkg::tcep_chan_ctl_t ch2_shd;

    assign ch1_shd = {cep_q[`TCEP_CH1_NPOL_BIT], cep_q[`TCEP_CH1_NEN_BIT],
                      cep_q[`TCEP_CH1_POL_BIT], cep_q[`TCEP_CH1_EN_BIT]};
    assign ch2_shd = {cep_q[`TCEP_CH2_NPOL_BIT], 1'b0,
                      cep_q[`TCEP_CH2_POL_BIT], cep_q[`TCEP_CH2_EN_BIT]};

    // ----------------------------------------------------------------
    // effective controls
    // ----------------------------------------------------------------
    tcep_pkg::tcep_chan_ctl_t ch1_eff_q;
    tcep_pkg::tcep_chan_ctl_t ch2_eff_q;

    // ch1 is the complementary channel: with preload it moves on commutation
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_eff_q <= '0;
        end else if (!control_preload_enable || commutation_event) begin
            ch1_eff_q <= ch1_shd;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ch2_eff_q <= '0;
        end else begin
            ch2_eff_q <= ch2_shd;
        end
    end

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    tcep_pkg::tcep_brk_t brk;
    tcep_pkg::tcep_pin_t ch1_main_d;
    tcep_pkg::tcep_pin_t ch1_comp_d;
    tcep_pkg::tcep_pin_t ch2_main_d;
    logic                ch1_is_out;
    logic                ch2_is_out;

    assign brk        = {main_output_enable, idle_offstate_select, run_offstate_select};
    assign ch1_is_out = is_out(ch1_direction_select);
    assign ch2_is_out = is_out(ch2_direction_select);

    tcep_chan_out u_ch1_out (
        .ctl           (ch1_eff_q),
        .brk           (brk),
        .idle_lvl      (ch1_idle_level),
        .comp_idle_lvl (ch1_comp_idle_level),
        .ref_sig       (ch1_reference_signal),
        .is_output     (ch1_is_out),
        .main_pin      (ch1_main_d),
        .comp_pin      (ch1_comp_d)
    );

    tcep_chan_out u_ch2_out (
        .ctl           (ch2_eff_q),
        .brk           (brk),
        .idle_lvl      (ch2_idle_level),
        .comp_idle_lvl (1'b0),
        .ref_sig       (ch2_reference_signal),
        .is_output     (ch2_is_out),
        .main_pin      (ch2_main_d),
        .comp_pin      ()
    );

    // pin levels and enables, one flop stage
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_main_output <= 1'b0;
            ch1_main_oe     <= 1'b0;
            ch1_comp_output <= 1'b0;
            ch1_comp_oe     <= 1'b0;
            ch2_main_output <= 1'b0;
            ch2_main_oe     <= 1'b0;
        end else begin
            ch1_main_output <= ch1_main_d.lvl;
            ch1_main_oe     <= ch1_main_d.oe;
            ch1_comp_output <= ch1_comp_d.lvl;
            ch1_comp_oe     <= ch1_comp_d.oe;
            ch2_main_output <= ch2_main_d.lvl;
            ch2_main_oe     <= ch2_main_d.oe;
        end
    end

    // ----------------------------------------------------------------
    // input stage
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_capture_en <= 1'b0;
            ch2_capture_en <= 1'b0;
            ch1_edge_rise  <= 1'b0;
            ch1_edge_fall  <= 1'b0;
            ch2_edge_rise  <= 1'b0;
            ch2_edge_fall  <= 1'b0;
            ch1_input_cond <= 1'b0;
            ch2_input_cond <= 1'b0;
        end else begin
            ch1_capture_en <= !ch1_is_out && ch1_eff_q.out_en;
            ch2_capture_en <= !ch2_is_out && ch2_eff_q.out_en;
            {ch1_edge_rise, ch1_edge_fall} <= edge_sel(ch1_eff_q);
            {ch2_edge_rise, ch2_edge_fall} <= edge_sel(ch2_eff_q);
            // code 10 is never written by software, so it is not decoded apart
            ch1_input_cond <= ch1_filtered_input ^
                              (ch1_eff_q.pol & ~ch1_eff_q.comp_pol);
            ch2_input_cond <= ch2_filtered_input ^
                              (ch2_eff_q.pol & ~ch2_eff_q.comp_pol);
        end
    end

    // ----------------------------------------------------------------
    // bus answer: captured in setup, shown in the access cycle
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (setup_cyc) begin
            pready  <= 1'b1;
            pslverr <= !(hit_cep || hit_stat);
            if (hit_cep) begin
                prdata <= {24'h00_0000, cep_q};
            end else if (hit_stat) begin
                prdata <= {24'h00_0000, pack_word(ch1_eff_q, ch2_eff_q)};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_cep_write;
        psel && penable && pready && pwrite && hit_cep;
    endsequence

    sequence s_direct_apply;
        s_cep_write ##1 !control_preload_enable;
    endsequence

    a_lock_pol_hold: assert property ((s_cep_write and prot1) |=>
        $stable(cep_q[`TCEP_CH1_POL_BIT]))
        else $error("ch1 polarity changed under lock");

    a_lock_npol_hold: assert property ((s_cep_write and prot_n1) |=>
        $stable(cep_q[`TCEP_CH1_NPOL_BIT]))
        else $error("ch1 comp polarity changed under lock");

    a_free_write: assert property ((s_cep_write and !prot1) |=>
        cep_q == ($past(pwdata[7:0]) & `TCEP_CEP_MASK))
        else $error("written word not stored");

    a_direct_apply: assert property (s_direct_apply |=>
        ch1_eff_q == $past(ch1_shd))
        else $error("write not applied without preload");

    a_preload_hold: assert property (control_preload_enable &&
        !commutation_event |=> $stable(ch1_eff_q))
        else $error("effective bits moved without commutation");

    a_comm_load: assert property (control_preload_enable &&
        commutation_event |=> ch1_eff_q == $past(ch1_shd))
        else $error("commutation did not load shadow");

    a_main_drive: assert property (ch1_is_out && main_output_enable &&
        !run_offstate_select && ch1_eff_q.out_en && !ch1_eff_q.comp_en |=>
        ch1_main_oe && ch1_main_output == $past(ch1_reference_signal ^ ch1_eff_q.pol))
        else $error("main output not reference xor polarity");

    a_main_off: assert property (ch1_is_out && main_output_enable &&
        !run_offstate_select && !ch1_eff_q.out_en |=> !ch1_main_oe && !ch1_main_output)
        else $error("disabled main output driven");

    a_comp_drive: assert property (ch1_is_out && main_output_enable &&
        !run_offstate_select && !ch1_eff_q.out_en && ch1_eff_q.comp_en |=>
        ch1_comp_oe && ch1_comp_output == $past(ch1_reference_signal ^ ch1_eff_q.comp_pol))
        else $error("comp output not reference xor comp polarity");

    a_edge_code: assert property (!ch1_is_out |=>
        ch1_edge_fall == $past(ch1_eff_q.pol) &&
        ch1_edge_rise == $past(!(ch1_eff_q.pol && !ch1_eff_q.comp_pol)))
        else $error("edge sensitivity mismatch");

    a_input_inv: assert property (ch1_eff_q.pol && !ch1_eff_q.comp_pol |=>
        ch1_input_cond != $past(ch1_filtered_input))
        else $error("input not inverted for code 01");

    a_capture_en: assert property (!ch1_is_out |=>
        ch1_capture_en == $past(ch1_eff_q.out_en) && !ch1_main_oe)
        else $error("capture enable mismatch");

    a_rsvd_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("reserved read bits not zero");

endmodule : tcep_top

`default_nettype wire

// file: pkg/tcep_map.svh
`ifndef TCEP_MAP_SVH
`define TCEP_MAP_SVH

// register byte offsets, reset value and write mask
`define TCEP_CEP_OFF      8'h20
`define TCEP_STAT_OFF     8'h30
`define TCEP_CEP_RST      8'h00
`define TCEP_CEP_MASK     8'hBF

// field positions inside the enable/polarity word
`define TCEP_CH1_EN_BIT   0
`define TCEP_CH1_POL_BIT  1
`define TCEP_CH1_NEN_BIT  2
`define TCEP_CH1_NPOL_BIT 3
`define TCEP_CH2_EN_BIT   4
`define TCEP_CH2_POL_BIT  5
`define TCEP_CH2_NPOL_BIT 7

// lock level from which polarity bits are frozen
`define TCEP_LOCK_PROT    2'h2
// direction code of an output channel
`define TCEP_DIR_OUT      2'h0

`endif

// file: pkg/tcep_pkg.sv
package tcep_pkg;

    // one channel's enable and polarity controls
    typedef struct packed {
        logic comp_pol;
        logic comp_en;
        logic pol;
        logic out_en;
    } tcep_chan_ctl_t;

    // break and off-state controls shared by the channels
    typedef struct packed {
        logic main_output_enable;
        logic idle_offstate_select;
        logic run_offstate_select;
    } tcep_brk_t;

    // level and output enable of one pin
    typedef struct packed {
        logic lvl;
        logic oe;
    } tcep_pin_t;

endpackage : tcep_pkg
